// ---- rtl/ers_reset_seq.sv ----
// Reset sequencer of the Ethernet controller with AXI4-Lite register slave
`timescale 1ns/10ps
`default_nettype none
`include "ers_map.svh"

//------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------
// Overview of operation
// RULE1: Power-on holds internal reset about 22 ms
// RULE2: Ready reads 0 during power-on reset
// RULE3: Reset pin low resets; ready after
// RULE4: Reset pin pulled up when unconnected
// RULE5: Ready set within 2 ms after wake
// RULE6: Soft reset bit 0 starts soft reset
// RULE7: Soft reset bit self-clears after 2 us
// RULE8: Soft reset keeps retained register bits
// RULE9: Soft reset leaves host bus logic alone
// RULE10: Control bit 10 resets PHY only
// RULE11: PHY reset bit clears after 100 us
// RULE12: PHY control bit 15 self-clearing reset
// RULE13: EEPROM probed after full resets, busy set
// RULE14: Host waits EEPROM busy clear first
// RULE15: Host waits link status after PHY reset
// RULE16: Host flags error if not ready 100ms
// RULE17: Any wake register write ends sleep
// RULE18: Host only reads until ready set
// RULE19: Ready cleared when full reset begins
module ers_reset_seq #(
    parameter int POR_CYCLES = `ERS_POR_CYC,
    parameter int WAKE_CYCLES = `ERS_WAKE_CYC,
    parameter int PHYRST_CYCLES = `ERS_PHYRST_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hardware_reset_pin_n,
    input wire logic eeprom_present,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic core_reset,
    output logic phy_reset,
    output logic device_ready,
    output logic eeprom_busy
);
    import ers_pkg::*;

    localparam logic [23:0] POR_LAST = 24'(POR_CYCLES - 1);
    localparam logic [23:0] WAKE_LAST = 24'(WAKE_CYCLES - 1);
    localparam logic [15:0] PHY_LAST = 16'(PHYRST_CYCLES - 1);
    localparam logic [23:0] SOFT_RESET_BIT_LAST = 24'(`ERS_SOFT_RESET_BIT_CYC - 1);
    localparam logic [9:0] PHYCTL_LAST = 10'(`ERS_PHYCTL_CYC - 1);
    localparam logic [9:0] PROBE_LAST = 10'(`ERS_PROBE_CYC - 1);

    ers_regs_t r;
    ers_regs_t next_r;
    logic wr_go;
    logic rd_go;
    logic full_rst;

    // Pin pull-up is external; low on the port means asserted
    assign full_rst = !rst_n || !hardware_reset_pin_n; // RULE3 RULE4

    //------------------------------------------------------------
    // Bus handshake
    //------------------------------------------------------------
    assign s_axi_awready = !r.aw_done && !r.bvalid;
    assign s_axi_wready = !r.w_done && !r.bvalid;
    assign s_axi_arready = !r.rvalid;
    assign wr_go = (r.aw_done || s_axi_awvalid) && (r.w_done || s_axi_wvalid) && !r.bvalid;
    assign rd_go = s_axi_arvalid && !r.rvalid;

    always_comb begin
        logic [7:0] wa;
        logic [31:0] wd;
        logic wstrb_lo;
        logic wstrb_hi;
        wa = r.aw_done ? r.awaddr : s_axi_awaddr;
        wd = r.w_done ? r.wdata : s_axi_wdata;
        wstrb_lo = s_axi_wstrb[0] || r.w_done;
        wstrb_hi = s_axi_wstrb[1] || r.w_done;
        next_r = r;

        // Timers first so that a restart write wins over the clear
        if (r.phy_rst) begin
            next_r.phy_cnt = r.phy_cnt + 16'h1;
            if (r.phy_cnt == PHY_LAST) begin
                next_r.phy_rst = 1'b0; // RULE11
            end
        end
        if (r.phyctl_rst) begin
            next_r.phyctl_cnt = r.phyctl_cnt + 10'h1;
            if (r.phyctl_cnt == PHYCTL_LAST) begin
                next_r.phyctl_rst = 1'b0; // RULE12
            end
        end

        //------------------------------------------------------------
        // Write channel
        //------------------------------------------------------------
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end
        if (s_axi_awvalid && s_axi_awready && !wr_go) begin
            next_r.aw_done = 1'b1;
            next_r.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready && !wr_go) begin
            next_r.w_done = 1'b1;
            next_r.wdata = s_axi_wdata;
        end
        if (wr_go) begin
            next_r.aw_done = 1'b0;
            next_r.w_done = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = 2'b00;
            case (wa)
                `ERS_WAKE_OFS: begin
                    if (r.st == ERS_ST_SLEEP) begin
                        next_r.st = ERS_ST_WAKE; // RULE17
                        next_r.cnt = 24'h0;
                        next_r.pm_mode = 2'h0;
                    end
                end
                `ERS_HWCFG_OFS: begin
                    if (r.ready && wstrb_lo && wd[`ERS_SOFT_RESET_BIT_BIT]) begin
                        next_r.st = ERS_ST_SOFT_RESET_BIT; // RULE6
                        next_r.soft_reset_bit = 1'b1;
                        next_r.ready = 1'b0; // RULE19
                        next_r.cnt = 24'h0;
                    end
                end
                `ERS_PMT_OFS: begin
                    if (r.ready && wstrb_hi && wd[`ERS_PHYRST_BIT]) begin
                        next_r.phy_rst = 1'b1; // RULE10
                        next_r.phy_cnt = 16'h0;
                    end
                    if (r.ready && wstrb_hi && wd[`ERS_PMMODE_LO+1 -: 2] != 2'h0) begin
                        next_r.pm_mode = wd[`ERS_PMMODE_LO+1 -: 2];
                        next_r.st = ERS_ST_SLEEP;
                        next_r.ready = 1'b0;
                    end
                end
                `ERS_PHYCTL_OFS: begin
                    if (r.ready && wstrb_hi && wd[`ERS_PHYCTL_RST]) begin
                        next_r.phyctl_rst = 1'b1; // RULE12
                        next_r.phyctl_cnt = 10'h0;
                    end
                end
                `ERS_RETAIN_OFS: begin
                    if (r.ready) begin
                        next_r.retain = wd;
                    end
                end
                `ERS_E2P_OFS, `ERS_STATUS_OFS: begin
                    next_r.bresp = 2'b00;
                end
                default: begin
                    next_r.bresp = 2'b10;
                end
            endcase
        end

        //------------------------------------------------------------
        // Read channel
        //------------------------------------------------------------
        if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end
        if (rd_go) begin
            next_r.rvalid = 1'b1;
            next_r.rresp = 2'b00;
            next_r.rdata = 32'h0;
            case (s_axi_araddr)
                `ERS_WAKE_OFS: next_r.rdata = 32'h0;
                `ERS_HWCFG_OFS: next_r.rdata[`ERS_SOFT_RESET_BIT_BIT] = r.soft_reset_bit;
                `ERS_PMT_OFS: begin
                    next_r.rdata[`ERS_READY_BIT] = r.ready; // RULE2
                    next_r.rdata[`ERS_PHYRST_BIT] = r.phy_rst;
                    next_r.rdata[`ERS_PMMODE_LO+1 -: 2] = r.pm_mode;
                end
                `ERS_PHYCTL_OFS: next_r.rdata[`ERS_PHYCTL_RST] = r.phyctl_rst;
                `ERS_E2P_OFS: next_r.rdata[`ERS_E2P_BUSY] = r.e2p_busy;
                `ERS_STATUS_OFS: begin
                    next_r.rdata[0] = r.eeprom_found;
                    next_r.rdata[3:1] = r.st;
                end
                `ERS_RETAIN_OFS: next_r.rdata = r.retain;
                default: next_r.rresp = 2'b10;
            endcase
        end

        //------------------------------------------------------------
        // Reset sequence
        //------------------------------------------------------------
        case (r.st)
            ERS_ST_POR: begin
                next_r.cnt = r.cnt + 24'h1;
                if (r.cnt == POR_LAST) begin
                    next_r.st = ERS_ST_RUN; // RULE1
                    next_r.ready = 1'b1; // RULE2 RULE3
                    next_r.e2p_busy = 1'b1; // RULE13
                    next_r.probe_cnt = 10'h0;
                end
            end
            ERS_ST_SOFT_RESET_BIT: begin
                next_r.cnt = r.cnt + 24'h1;
                if (r.cnt == SOFT_RESET_BIT_LAST) begin
                    next_r.st = ERS_ST_RUN;
                    next_r.soft_reset_bit = 1'b0; // RULE7
                    next_r.ready = 1'b1;
                    next_r.e2p_busy = 1'b1; // RULE13
                    next_r.probe_cnt = 10'h0;
                end
            end
            ERS_ST_WAKE: begin
                next_r.cnt = r.cnt + 24'h1;
                if (r.cnt == WAKE_LAST) begin
                    next_r.st = ERS_ST_RUN;
                    next_r.ready = 1'b1; // RULE5
                end
            end
            ERS_ST_RUN, ERS_ST_SLEEP: begin
                // Idle at zero so the next sequence counts from the start
                next_r.cnt = 24'h0;
            end
            default: begin
                next_r.st = ERS_ST_POR;
                next_r.cnt = 24'h0;
            end
        endcase

        // EEPROM presence probe
        if (r.e2p_busy && r.st != ERS_ST_SOFT_RESET_BIT) begin
            next_r.probe_cnt = r.probe_cnt + 10'h1;
            if (r.probe_cnt == PROBE_LAST) begin
                next_r.e2p_busy = 1'b0; // RULE13
                next_r.eeprom_found = eeprom_present;
            end
        end
    end

    //------------------------------------------------------------
    // State register
    //------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (full_rst) begin
            r <= '0; // RULE19
            r.st <= ERS_ST_POR; // RULE1 RULE3
            r.retain <= `ERS_RETAIN_RST;
        end else begin
            r <= next_r; // RULE8 RULE9
        end
    end

    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
    assign core_reset = (r.st == ERS_ST_POR) || (r.st == ERS_ST_SOFT_RESET_BIT);
    assign phy_reset = r.phy_rst || r.phyctl_rst || (r.st == ERS_ST_POR);
    assign device_ready = r.ready;
    assign eeprom_busy = r.e2p_busy;

    //------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------
    AST_READY_LOW_IN_POR: assert property (@(posedge mclk) disable iff (full_rst) // RULE2
        r.st == ERS_ST_POR |-> !device_ready)
        else $error("ready set during power-on");
    AST_RESET_CLEARS: assert property (@(posedge mclk) // RULE3
        !hardware_reset_pin_n |=> !device_ready && core_reset)
        else $error("pin reset ignored");
    AST_POR_TIME: assert property (@(posedge mclk) disable iff (full_rst) // RULE1
        $past(r.st) == ERS_ST_POR && r.st == ERS_ST_RUN |-> $past(r.cnt) == POR_LAST)
        else $error("power-on hold length wrong");
    AST_CORE_IN_SOFT_RESET_BIT: assert property (@(posedge mclk) disable iff (full_rst) // RULE6
        $rose(r.soft_reset_bit) |-> core_reset && !device_ready)
        else $error("soft reset did not start");
    AST_SOFT_RESET_BIT_LEN: assert property (@(posedge mclk) disable iff (full_rst) // RULE7
        $rose(r.soft_reset_bit) |-> r.soft_reset_bit [*8] ##[1:600] !r.soft_reset_bit)
        else $error("soft reset length wrong");
    AST_SOFT_RESET_BIT_KEEPS: assert property (@(posedge mclk) disable iff (full_rst) // RULE8
        r.st == ERS_ST_SOFT_RESET_BIT |=> $stable(r.retain))
        else $error("retained bits changed");
    AST_SOFT_RESET_BIT_BUS: assert property (@(posedge mclk) disable iff (full_rst) // RULE9
        r.st == ERS_ST_SOFT_RESET_BIT && rd_go |=> s_axi_rvalid)
        else $error("bus stalled in soft reset");
    AST_SOFT_RESET_BIT_READY: assert property (@(posedge mclk) disable iff (full_rst) // RULE13
        $fell(r.soft_reset_bit) |-> device_ready && eeprom_busy)
        else $error("no ready or probe");
    AST_PROBE_LEN: assert property (@(posedge mclk) disable iff (full_rst) // RULE13
        $fell(eeprom_busy) |-> $past(r.probe_cnt) == PROBE_LAST)
        else $error("probe length wrong");
    AST_PHY_ONLY: assert property (@(posedge mclk) disable iff (full_rst) // RULE10
        $rose(r.phy_rst) |-> !core_reset && $stable(r.st))
        else $error("phy reset hit core");
    AST_PHY_CLEAR: assert property (@(posedge mclk) disable iff (full_rst) // RULE11
        $fell(r.phy_rst) |-> $past(r.phy_cnt) == PHY_LAST)
        else $error("phy reset timing wrong");
    AST_PHYCTL_ONLY: assert property (@(posedge mclk) disable iff (full_rst) // RULE12
        $rose(r.phyctl_rst) |-> !core_reset && $stable(r.st))
        else $error("phy control reset hit core");
    AST_PHYCTL_CLEAR: assert property (@(posedge mclk) disable iff (full_rst) // RULE12
        $rose(r.phyctl_rst) |-> ##[1:600] !r.phyctl_rst)
        else $error("phy control bit stuck");
    AST_PHYCTL_TIME: assert property (@(posedge mclk) disable iff (full_rst) // RULE12
        $fell(r.phyctl_rst) |-> $past(r.phyctl_cnt) == PHYCTL_LAST)
        else $error("phy control timing wrong");
    AST_WAKE: assert property (@(posedge mclk) disable iff (full_rst) // RULE17
        r.st == ERS_ST_SLEEP && wr_go && (r.aw_done ? r.awaddr : s_axi_awaddr) == `ERS_WAKE_OFS
        |=> r.st == ERS_ST_WAKE)
        else $error("wake write ignored");
    AST_WAKE_DONE: assert property (@(posedge mclk) disable iff (full_rst) // RULE5
        r.st == ERS_ST_WAKE && r.cnt == WAKE_LAST |=> device_ready)
        else $error("wake too slow");
    AST_SLEEP_NOT_READY: assert property (@(posedge mclk) disable iff (full_rst) // RULE5
        r.st == ERS_ST_SLEEP |-> !device_ready)
        else $error("ready set while asleep");
    AST_WAKE_MODE: assert property (@(posedge mclk) disable iff (full_rst) // RULE17
        $rose(device_ready) && $past(r.st) == ERS_ST_WAKE |-> r.pm_mode == 2'h0)
        else $error("power mode kept after wake");

    //------------------------------------------------------------
    // Cover points
    //------------------------------------------------------------
    COV_POR_DONE: cover property (@(posedge mclk) $rose(device_ready));
    COV_SOFT_RESET_BIT: cover property (@(posedge mclk) $fell(r.soft_reset_bit));
    COV_PHY: cover property (@(posedge mclk) $fell(r.phy_rst));
    COV_WAKE: cover property (@(posedge mclk) r.st == ERS_ST_WAKE ##1 r.st == ERS_ST_RUN);
    COV_PIN_RESET: cover property (@(posedge mclk) !hardware_reset_pin_n ##1 hardware_reset_pin_n);
endmodule
`default_nettype wire

// ---- rtl/ers_map.svh ----
// Register offsets, field positions and timing counts of the reset sequencer
`ifndef ERS_MAP_SVH
`define ERS_MAP_SVH

// Register byte offsets
`define ERS_WAKE_OFS      8'h00
`define ERS_HWCFG_OFS     8'h04
`define ERS_PMT_OFS       8'h08
`define ERS_PHYCTL_OFS    8'h0c
`define ERS_E2P_OFS       8'h10
`define ERS_STATUS_OFS    8'h14
`define ERS_RETAIN_OFS    8'h18

// Field positions
`define ERS_SOFT_RESET_BIT_BIT      0
`define ERS_READY_BIT     0
`define ERS_PHYRST_BIT    10
`define ERS_PMMODE_LO     12
`define ERS_PHYCTL_RST    15
`define ERS_E2P_BUSY      31

// Reset values
`define ERS_HWCFG_RST     32'h0000_0000
`define ERS_RETAIN_RST    32'h0000_0000

// Times and clock rate
`define ERS_CLK_MHZ       250
`define ERS_POR_US        22000
`define ERS_WAKE_US       2000
`define ERS_SOFT_RESET_BIT_NS       2000
`define ERS_PHYRST_US     100
`define ERS_PHYCTL_NS     2000
`define ERS_PROBE_NS      1000
`define ERS_POR_CYC       (`ERS_POR_US * `ERS_CLK_MHZ)
`define ERS_WAKE_CYC      (`ERS_WAKE_US * `ERS_CLK_MHZ)
`define ERS_SOFT_RESET_BIT_CYC      (`ERS_SOFT_RESET_BIT_NS * `ERS_CLK_MHZ / 1000)
`define ERS_PHYRST_CYC    (`ERS_PHYRST_US * `ERS_CLK_MHZ)
`define ERS_PHYCTL_CYC    (`ERS_PHYCTL_NS * `ERS_CLK_MHZ / 1000)
`define ERS_PROBE_CYC     (`ERS_PROBE_NS * `ERS_CLK_MHZ / 1000)

`endif

// ---- rtl/ers_pkg.sv ----
// Types of the reset sequencer
package ers_pkg;
    typedef enum logic [2:0] {
        ERS_ST_POR = 3'b000,
        ERS_ST_SOFT_RESET_BIT = 3'b001,
        ERS_ST_RUN = 3'b010,
        ERS_ST_SLEEP = 3'b011,
        ERS_ST_WAKE = 3'b100
    } ers_state_t;

    typedef struct packed {
        ers_state_t st;
        logic [23:0] cnt;
        logic [15:0] phy_cnt;
        logic [9:0] phyctl_cnt;
        logic [9:0] probe_cnt;
        logic ready;
        logic soft_reset_bit;
        logic phy_rst;
        logic phyctl_rst;
        logic e2p_busy;
        logic eeprom_found;
        logic [1:0] pm_mode;
        logic [31:0] retain;
        logic aw_done;
        logic w_done;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ers_regs_t;
endpackage

// ---- testbench/ers_host_model.sv ----
// Host processor model: AXI4-Lite master of the reset sequencer registers
`timescale 1ns/10ps
`default_nettype none
module ers_host_model (
    input wire logic mclk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    end

    // Callers issue only reads and wake writes until ready reads set
    task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ha, hw, hb;
        hb = 1'b0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!hb) begin
            @(negedge mclk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid && bready;
            r = bresp;
            @(posedge mclk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask

    task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ha, hr;
        hr = 1'b0;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!hr) begin
            @(negedge mclk);
            ha = arvalid && arready;
            hr = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge mclk);
            if (ha) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- testbench/ers_reset_seq_bench.sv ----
// Self-checking bench of the reset sequencer
`timescale 1ns/10ps
`default_nettype none
`include "ers_map.svh"
module ers_reset_seq_bench;
    import ers_pkg::*;
    localparam int POR = 100;
    localparam int WAKE = 50;
    localparam int PHYR = 40;
    typedef struct {logic we; logic [7:0] a; logic [31:0] d, m, e; logic [1:0] r;} ers_row_t;
    logic mclk, rst_n, pin_n, eep;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, rs;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic core_reset, phy_reset, device_ready, eeprom_busy;
    logic [3:0] wstrb;
    int mismatches = 0;
    int check_count = 0;
    int n;
    ers_row_t rows[8] = '{
        '{1, `ERS_RETAIN_OFS, 32'ha5a5_5aa5, 32'h0, 32'h0, 2'b00},
        '{0, `ERS_RETAIN_OFS, 32'h0, 32'hffff_ffff, 32'ha5a5_5aa5, 2'b00},
        '{0, `ERS_E2P_OFS, 32'h0, 32'h8000_0000, 32'h0, 2'b00},
        '{0, `ERS_STATUS_OFS, 32'h0, 32'h1, 32'h1, 2'b00},
        '{0, `ERS_PHYCTL_OFS, 32'h0, 32'h8000, 32'h0, 2'b00},
        '{1, 8'h1c, 32'h5, 32'h0, 32'h0, 2'b10},
        '{0, 8'h1c, 32'h0, 32'h0, 32'h0, 2'b10},
        '{0, `ERS_PMT_OFS, 32'h0, 32'h1, 32'h1, 2'b00}};

    ers_reset_seq #(.POR_CYCLES(POR), .WAKE_CYCLES(WAKE), .PHYRST_CYCLES(PHYR)) dut (.mclk(mclk), .rst_n(rst_n),
        .hardware_reset_pin_n(pin_n), .eeprom_present(eep), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_reset(core_reset),
        .phy_reset(phy_reset), .device_ready(device_ready), .eeprom_busy(eeprom_busy));

    ers_host_model host (.mclk(mclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Sample a status output each cycle until it reaches lvl, bounded
    task automatic wait_lvl(input int sel, input logic lvl, input int lim, output int cnt);
        logic v;
        cnt = 0;
        v = ~lvl;
        while (v !== lvl && cnt < lim) begin
            @(negedge mclk);
            case (sel)
                0: v = device_ready;
                1: v = eeprom_busy;
                2: v = core_reset;
                default: v = phy_reset;
            endcase
            cnt++;
        end
        if (v !== lvl) begin
            mismatches++;
            $display("CHECK FAILED %0t wait limit on output %0d", $time, sel);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #200000;
        mismatches++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        end_sim();
    end

    initial begin
        rst_n = 1'b0;
        pin_n = 1'b1;
        eep = 1'b1;
        wstrb = 4'hf;
        repeat (20) @(posedge mclk);
        check(device_ready, 1'b0);
        check(core_reset, 1'b1);
        rst_n <= 1'b1;
        host.read(`ERS_PMT_OFS, rd, rs);
        check(rd[`ERS_READY_BIT], 1'b0);
        wait_lvl(0, 1'b1, 200, n);
        check(n >= POR - 8 && n <= POR + 4, 1'b1);
        check(eeprom_busy, 1'b1);
        wait_lvl(1, 1'b0, 400, n);
        $display("power-on test done");
        foreach (rows[i]) begin
            if (rows[i].we) host.write(rows[i].a, rows[i].d, rs);
            else host.read(rows[i].a, rd, rs);
            check(rs, rows[i].r);
            if (!rows[i].we) check(rd & rows[i].m, rows[i].e);
        end
        $display("register table test done");
        wstrb <= 4'he;
        host.write(`ERS_HWCFG_OFS, 32'h1, rs);
        check({core_reset, device_ready}, 2'b01);
        wstrb <= 4'hf;
        host.write(`ERS_HWCFG_OFS, 32'h1, rs);
        check(core_reset, 1'b1);
        host.read(`ERS_HWCFG_OFS, rd, rs);
        check(rd[`ERS_SOFT_RESET_BIT_BIT], 1'b1);
        wait_lvl(2, 1'b0, 700, n);
        check(n >= 470 && n <= 505, 1'b1);
        host.read(`ERS_HWCFG_OFS, rd, rs);
        check(rd[`ERS_SOFT_RESET_BIT_BIT], 1'b0);
        check(eeprom_busy, 1'b1);
        wait_lvl(1, 1'b0, 400, n);
        wait_lvl(0, 1'b1, 50, n);
        host.read(`ERS_RETAIN_OFS, rd, rs);
        check(rd, 32'ha5a5_5aa5);
        $display("soft reset test done");
        host.write(`ERS_PMT_OFS, 32'h400, rs);
        check({phy_reset, core_reset, device_ready}, 3'b101);
        wait_lvl(3, 1'b0, 100, n);
        check(n >= PHYR - 8 && n <= PHYR + 2, 1'b1);
        host.read(`ERS_PMT_OFS, rd, rs);
        check(rd[`ERS_PHYRST_BIT], 1'b0);
        host.write(`ERS_PHYCTL_OFS, 32'h8000, rs);
        host.read(`ERS_PHYCTL_OFS, rd, rs);
        check({rd[`ERS_PHYCTL_RST], phy_reset}, 2'b11);
        wait_lvl(3, 1'b0, 700, n);
        host.read(`ERS_PHYCTL_OFS, rd, rs);
        check(rd[`ERS_PHYCTL_RST], 1'b0);
        $display("PHY reset test done");
        host.write(`ERS_PMT_OFS, 32'h1000, rs);
        wait_lvl(0, 1'b0, 10, n);
        host.write(`ERS_WAKE_OFS, 32'h0, rs);
        wait_lvl(0, 1'b1, WAKE + 4, n);
        check(n <= WAKE + 2, 1'b1);
        host.read(`ERS_PMT_OFS, rd, rs);
        check({rd[13:12], eeprom_busy}, 3'b000);
        $display("wake test done");
        @(posedge mclk);
        pin_n <= 1'b0;
        eep <= 1'b0;
        repeat (3) @(posedge mclk);
        pin_n <= 1'b1;
        check({device_ready, core_reset}, 2'b01);
        wait_lvl(0, 1'b1, 200, n);
        check(eeprom_busy, 1'b1);
        wait_lvl(1, 1'b0, 400, n);
        host.read(`ERS_STATUS_OFS, rd, rs);
        check(rd[0], 1'b0);
        host.read(`ERS_RETAIN_OFS, rd, rs);
        check(rd, `ERS_RETAIN_RST);
        $display("reset pin test done");
        end_sim();
    end
endmodule
`default_nettype wire
